// File: rtl/dps_synth_ctrl.sv
// Control block for the pixel and memory clock synthesizers
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module dps_synth_ctrl (
  // Clock and reset
  input  wire logic                 CLK_I,
  input  wire logic                 RST_N_I,
  // Register port
  input  wire dps_pkg::dps_bus_type BUS_I,
  output logic [7:0]                RDATA_O,
  // Synthesized pixel clock pin, sampled
  input  wire logic                 PIXEL_CLOCK_I,
  // Loop settings
  output dps_pkg::dps_cfg_type      PIXEL_CFG_O,
  output dps_pkg::dps_cfg_type      MEM_CFG_O,
  output logic                      MEM_CLK_SEL_O,
  output logic [1:0]                PIXEL_SET_O,
  // Events
  output logic                      PIXEL_RETUNE_O,
  output logic                      MEM_RETUNE_O,
  output logic                      PIXEL_POST_STEP_O,
  output logic                      MEM_POST_STEP_O,
  output logic                      CHAR_TICK_O
);
  import dps_pkg::*;

  typedef struct packed {
    logic [NREGS-1:0][7:0] regs;
    logic [7:0]            rdata;
    dps_cfg_type           pix_cfg;
    dps_cfg_type           mem_cfg;
    logic [1:0]            pix_set;
    logic                  mem_sel;
    logic                  pix_retune;
    logic                  mem_retune;
    logic                  pix_step;
    logic                  mem_step;
    logic [2:0]            pin_sync;
    logic                  pin_level;
    logic [2:0]            char_cnt;
    logic                  char_tick;
  } dps_state_type;

  dps_state_type st_reg;
  dps_state_type st_next;
  logic [3:0]    widx;
  logic [3:0]    ridx;

  assign widx = BUS_I.addr[3:0];
  assign ridx = BUS_I.addr[3:0];

  // Post code to ratio; codes above 5 saturate at 32
  function automatic logic [5:0] post_ratio(input logic [2:0] code);
    logic [2:0] c;
    c = (code > POST_CODE_MAX) ? POST_CODE_MAX : code;
    return 6'h01 << c;
  endfunction

  // Pixel set decode: low bytes, shared high bits, post divider register
  function automatic dps_cfg_type pixel_cfg(input logic [7:0] m_lo, input logic [7:0] n_lo,
                                            input logic [7:0] hi, input logic [7:0] pd);
    dps_cfg_type c;
    c.mult_count = {hi[MULT_HI_LSB+:2], m_lo} + DIVIDER_OFFSET;
    c.div_count  = {hi[DIV_HI_LSB+:2], n_lo} + DIVIDER_OFFSET;
    c.post_ratio = post_ratio(pd[POST_LSB+:3]);
    c.loop_div16 = ~pd[LOOP_DIV_BIT];
    c.ref_div4   = pd[REF_DIV_BIT];
    c.ntsc_div   = pd[NTSC_DIV_BIT];
    return c;
  endfunction

  dps_cfg_type cfg_set [3];
  dps_cfg_type mem_cfg_now;
  logic [1:0]  sel_now;

  // One decoder per pixel set
  for (genvar g = 0; g < 3; g++) begin : g_set
    assign cfg_set[g] = pixel_cfg(st_reg.regs[4*g], st_reg.regs[4*g+1],
                                  st_reg.regs[4*g+2], st_reg.regs[4*g+3]);
  end

  // Misc select value 3 falls back to set two
  assign sel_now = (st_reg.regs[OFS_MISC_OUTPUT[3:0]][CLK_SEL_LSB+:2] == 2'h3) ? 2'h2 :
                   st_reg.regs[OFS_MISC_OUTPUT[3:0]][CLK_SEL_LSB+:2];

  always_comb begin
    mem_cfg_now.mult_count = {3'h0, st_reg.regs[OFS_MEM_MULT[3:0]][6:0]} + DIVIDER_OFFSET;
    mem_cfg_now.div_count  = {3'h0, st_reg.regs[OFS_MEM_DIV[3:0]][6:0]} + DIVIDER_OFFSET;
    mem_cfg_now.post_ratio = post_ratio(st_reg.regs[OFS_MEM_CONTROL[3:0]][POST_LSB+:3]);
    mem_cfg_now.loop_div16 = ~st_reg.regs[OFS_MEM_CONTROL[3:0]][LOOP_DIV_BIT];
    mem_cfg_now.ref_div4   = st_reg.regs[OFS_MEM_CONTROL[3:0]][REF_DIV_BIT];
    mem_cfg_now.ntsc_div   = st_reg.regs[OFS_MEM_CONTROL[3:0]][NTSC_DIV_BIT];
  end

  always_comb begin
    st_next = st_reg;
    // Writes land at once; no commit step, so the loop retunes next cycle
    if (BUS_I.wr && BUS_I.addr <= OFS_LAST) begin
      st_next.regs[widx] = BUS_I.wdata;
    end
    // Read data stands for one cycle only; unmapped reads give zero
    st_next.rdata = 8'h00;
    if (BUS_I.rd && BUS_I.addr <= OFS_LAST) begin
      st_next.rdata = st_reg.regs[ridx];
    end
    st_next.pix_set = sel_now;
    st_next.pix_cfg = cfg_set[sel_now];
    st_next.mem_cfg = mem_cfg_now;
    st_next.mem_sel = st_reg.regs[OFS_MEM_CONTROL[3:0]][MEM_SEL_BIT];
    st_next.pix_retune = (cfg_set[sel_now] != st_reg.pix_cfg);
    st_next.mem_retune = (mem_cfg_now != st_reg.mem_cfg);
    // Post ratio switches without waiting for lock; flag the glitch window
    st_next.pix_step = (cfg_set[sel_now].post_ratio != st_reg.pix_cfg.post_ratio);
    st_next.mem_step = (mem_cfg_now.post_ratio != st_reg.mem_cfg.post_ratio);
    // Three-stage pin sampler; level moves only when stages two and three agree
    st_next.pin_sync = {st_reg.pin_sync[1:0], PIXEL_CLOCK_I};
    if (st_reg.pin_sync[1] == st_reg.pin_sync[2]) begin
      st_next.pin_level = st_reg.pin_sync[2];
    end
    // Character clock: one tick per eight filtered pixel clock rising edges
    st_next.char_tick = 1'b0;
    if (st_next.pin_level && !st_reg.pin_level) begin
      st_next.char_cnt = st_reg.char_cnt + 3'h1;
      if (st_reg.char_cnt == CHAR_LAST) begin
        st_next.char_tick = 1'b1;
      end
    end
  end

  // Reset image of the register file
  function automatic logic [NREGS-1:0][7:0] reset_regs();
    logic [NREGS-1:0][7:0] r;
    r = '0;
    for (int s = 0; s < 3; s++) begin
      r[4*s]   = (s == 1) ? RST_MULT_28 : RST_MULT_25;
      r[4*s+1] = RST_DIV;
      r[4*s+2] = RST_HIGH;
      r[4*s+3] = RST_POST;
    end
    r[OFS_MEM_MULT[3:0]]    = RST_MULT_25;
    r[OFS_MEM_DIV[3:0]]     = RST_DIV;
    r[OFS_MEM_CONTROL[3:0]] = RST_MEM_CTL;
    r[OFS_MISC_OUTPUT[3:0]] = RST_MISC;
    return r;
  endfunction

  localparam logic [NREGS-1:0][7:0] REGS_RESET = reset_regs();
  localparam dps_cfg_type CFG_RESET_25 = pixel_cfg(RST_MULT_25, RST_DIV, RST_HIGH, RST_POST);

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_reg            <= '0;
      st_reg.regs       <= REGS_RESET;
      st_reg.pix_cfg    <= CFG_RESET_25;
      st_reg.mem_cfg    <= CFG_RESET_25;
    end else begin
      st_reg <= st_next;
    end
  end

  assign RDATA_O           = st_reg.rdata;
  assign PIXEL_CFG_O       = st_reg.pix_cfg;
  assign MEM_CFG_O         = st_reg.mem_cfg;
  assign MEM_CLK_SEL_O     = st_reg.mem_sel;
  assign PIXEL_SET_O       = st_reg.pix_set;
  assign PIXEL_RETUNE_O    = st_reg.pix_retune;
  assign MEM_RETUNE_O      = st_reg.mem_retune;
  assign PIXEL_POST_STEP_O = st_reg.pix_step;
  assign MEM_POST_STEP_O   = st_reg.mem_step;
  assign CHAR_TICK_O       = st_reg.char_tick;

  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_write_mem_ctl;
    BUS_I.wr && BUS_I.addr == OFS_MEM_CONTROL;
  endsequence

  a_mem_sel_follow: assert property (s_write_mem_ctl |-> ##2 MEM_CLK_SEL_O == $past(BUS_I.wdata[7], 2))
    else $error("memory clock select does not follow control bit 7");
  a_read_latency: assert property (BUS_I.rd && BUS_I.addr <= OFS_LAST && !BUS_I.wr
                                   |=> RDATA_O == $past(st_reg.regs[ridx]))
    else $error("read data wrong one cycle after strobe");
  a_unmapped_zero: assert property (BUS_I.rd && BUS_I.addr > OFS_LAST |=> RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  a_mem_mult_plus2: assert property (BUS_I.wr && BUS_I.addr == OFS_MEM_MULT
                                     |-> ##2 MEM_CFG_O.mult_count == {3'h0, $past(BUS_I.wdata[6:0], 2)} + 10'h002)
    else $error("memory multiplier count is not value plus two");
  a_mem_retune: assert property (BUS_I.wr && BUS_I.addr == OFS_MEM_DIV
                                 && BUS_I.wdata[6:0] != st_reg.regs[OFS_MEM_DIV[3:0]][6:0]
                                 |-> ##2 MEM_RETUNE_O)
    else $error("memory loop did not retune after divider write");
  a_pixel_set_pick: assert property (PIXEL_SET_O == 2'h1 |-> PIXEL_CFG_O.mult_count ==
                                     $past(cfg_set[1].mult_count))
    else $error("pixel set one not routed");
  a_post_ratio_max: assert property (PIXEL_CFG_O.post_ratio <= 6'h20 && MEM_CFG_O.post_ratio <= 6'h20)
    else $error("post ratio beyond 32");
  a_pix_post_glitch: assert property ($changed(PIXEL_CFG_O.post_ratio) |-> PIXEL_POST_STEP_O)
    else $error("post divider change not flagged at once");
  a_char_tick_gap: assert property (CHAR_TICK_O |=> !CHAR_TICK_O [*3])
    else $error("character ticks too close");
  a_pix_m_high: assert property (BUS_I.wr && BUS_I.addr == OFS_SET0_HIGH_BITS && PIXEL_SET_O == 2'h0
                                 && st_reg.regs[OFS_MISC_OUTPUT[3:0]][3:2] == 2'h0
                                 && !($past(BUS_I.wr) && $past(BUS_I.addr) == OFS_MISC_OUTPUT)
                                 |-> ##2 PIXEL_CFG_O.mult_count[9:8] ==
                                 2'(({$past(BUS_I.wdata[1:0], 2), st_reg.regs[0]} + 10'h002) >> 8))
    else $error("pixel multiplier high bits misplaced");

  // Steps of the memory reprogramming order
  sequence s_write_mem_mult;
    BUS_I.wr && BUS_I.addr == OFS_MEM_MULT;
  endsequence

  sequence s_write_mem_div;
    BUS_I.wr && BUS_I.addr == OFS_MEM_DIV;
  endsequence

  sequence s_clear_mem_sel;
    BUS_I.wr && BUS_I.addr == OFS_MEM_CONTROL && !BUS_I.wdata[MEM_SEL_BIT];
  endsequence

  sequence s_set_mem_sel;
    BUS_I.wr && BUS_I.addr == OFS_MEM_CONTROL && BUS_I.wdata[MEM_SEL_BIT];
  endsequence

  sequence s_write_misc;
    BUS_I.wr && BUS_I.addr == OFS_MISC_OUTPUT;
  endsequence

  sequence s_write_mapped;
    BUS_I.wr && BUS_I.addr <= OFS_LAST;
  endsequence

  // Fixed source first, so the bus keeps working while the loop slews
  a_mem_sel_fixed: assert property (s_clear_mem_sel |-> ##2 !MEM_CLK_SEL_O)
    else $error("memory clock not on fixed source after clear");

  a_mem_sel_loop: assert property (s_set_mem_sel |-> ##2 MEM_CLK_SEL_O)
    else $error("memory clock not on programmed loop after set");

  a_mem_mult_land: assert property (s_write_mem_mult
                                    |=> st_reg.regs[OFS_MEM_MULT[3:0]] == $past(BUS_I.wdata))
    else $error("memory multiplier write did not land");

  a_mem_div_plus2: assert property (s_write_mem_div
                                    |-> ##2 MEM_CFG_O.div_count == {3'h0, $past(BUS_I.wdata[6:0], 2)} + 10'h002)
    else $error("memory divider count is not value plus two");

  a_mem_post_code: assert property (s_write_mem_ctl
                                    |-> ##2 MEM_CFG_O.post_ratio ==
                                    (($past(BUS_I.wdata[6:4], 2) > 3'h5) ? 6'h20 :
                                     (6'h01 << $past(BUS_I.wdata[6:4], 2))))
    else $error("memory post ratio does not follow its code");

  a_mem_loop_bits: assert property (s_write_mem_ctl
                                    |-> ##2 MEM_CFG_O.loop_div16 == !$past(BUS_I.wdata[LOOP_DIV_BIT], 2)
                                    && MEM_CFG_O.ref_div4 == $past(BUS_I.wdata[REF_DIV_BIT], 2)
                                    && MEM_CFG_O.ntsc_div == $past(BUS_I.wdata[NTSC_DIV_BIT], 2))
    else $error("memory loop divide bits wrong");

  // Memory counts are seven bits plus two, so the top bits stay clear
  a_mem_high_clear: assert property (MEM_CFG_O.mult_count[9:8] == 2'h0
                                     && MEM_CFG_O.div_count[9:8] == 2'h0)
    else $error("memory count beyond seven bits plus two");

  a_pix_retune_exact: assert property (PIXEL_RETUNE_O == $changed(PIXEL_CFG_O))
    else $error("pixel retune pulse does not match a change");

  a_mem_retune_exact: assert property (MEM_RETUNE_O == $changed(MEM_CFG_O))
    else $error("memory retune pulse does not match a change");

  a_pix_step_exact: assert property (PIXEL_POST_STEP_O == $changed(PIXEL_CFG_O.post_ratio))
    else $error("pixel post step pulse does not match a change");

  a_mem_step_exact: assert property (MEM_POST_STEP_O == $changed(MEM_CFG_O.post_ratio))
    else $error("memory post step pulse does not match a change");

  a_post_onehot: assert property ($onehot(PIXEL_CFG_O.post_ratio) && $onehot(MEM_CFG_O.post_ratio))
    else $error("post ratio not a power of two");

  a_set_legal: assert property (PIXEL_SET_O != 2'h3)
    else $error("pixel set index out of range");

  a_set_follow: assert property (s_write_misc
                                 |-> ##2 PIXEL_SET_O ==
                                 (($past(BUS_I.wdata[CLK_SEL_LSB+:2], 2) == 2'h3) ? 2'h2 :
                                  $past(BUS_I.wdata[CLK_SEL_LSB+:2], 2)))
    else $error("pixel set does not follow misc output field");

  a_set_zero_route: assert property (PIXEL_SET_O == 2'h0 |-> PIXEL_CFG_O == $past(cfg_set[0]))
    else $error("pixel set zero not routed");

  a_set_two_route: assert property (PIXEL_SET_O == 2'h2 |-> PIXEL_CFG_O == $past(cfg_set[2]))
    else $error("pixel set two not routed");

  a_mapped_write: assert property (s_write_mapped |=> st_reg.regs[$past(widx)] == $past(BUS_I.wdata))
    else $error("register write did not land");

  // Unmapped writes must leave every register alone
  a_unmapped_write: assert property (BUS_I.wr && BUS_I.addr > OFS_LAST |=> st_reg.regs == $past(st_reg.regs))
    else $error("unmapped write changed a register");

  a_rdata_idle: assert property (!$past(BUS_I.rd) |-> RDATA_O == 8'h00)
    else $error("read data not zero outside its cycle");

  // Slow pin: the level may only move once two sampler stages agree
  a_pin_filter: assert property ($changed(st_reg.pin_level)
                                 |-> $past(st_reg.pin_sync[1]) == $past(st_reg.pin_sync[2])
                                 && st_reg.pin_level == $past(st_reg.pin_sync[2]))
    else $error("pixel clock level moved before stages agreed");

  a_char_wrap: assert property (CHAR_TICK_O |-> st_reg.char_cnt == 3'h0)
    else $error("character tick without counter wrap");

  a_char_on_rise: assert property (CHAR_TICK_O |-> st_reg.pin_level && !$past(st_reg.pin_level))
    else $error("character tick without pixel clock rise");

endmodule

// File: rtl/dps_pkg.sv
// Package for the dual clock synthesizer control block
package dps_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NREGS  = 16;

  // Register indices
  localparam logic [7:0] OFS_SET0_MULT_LOW  = 8'h00;
  localparam logic [7:0] OFS_SET0_DIV_LOW   = 8'h01;
  localparam logic [7:0] OFS_SET0_HIGH_BITS = 8'h02;
  localparam logic [7:0] OFS_SET0_POST_DIV  = 8'h03;
  localparam logic [7:0] OFS_SET1_MULT_LOW  = 8'h04;
  localparam logic [7:0] OFS_SET2_MULT_LOW  = 8'h08;
  localparam logic [7:0] OFS_MEM_MULT       = 8'h0c;
  localparam logic [7:0] OFS_MEM_DIV        = 8'h0d;
  localparam logic [7:0] OFS_MEM_CONTROL    = 8'h0e;
  localparam logic [7:0] OFS_MISC_OUTPUT    = 8'h0f;
  localparam logic [7:0] OFS_LAST           = 8'h0f;

  // Field positions
  localparam int MULT_HI_LSB = 0;
  localparam int DIV_HI_LSB  = 4;
  localparam int POST_LSB    = 4;
  localparam int LOOP_DIV_BIT = 0;
  localparam int REF_DIV_BIT  = 1;
  localparam int NTSC_DIV_BIT = 2;
  localparam int MEM_SEL_BIT  = 7;
  localparam int CLK_SEL_LSB  = 2;

  localparam logic [9:0] DIVIDER_OFFSET = 10'h002;
  localparam logic [2:0] POST_CODE_MAX  = 3'h5;
  localparam logic [2:0] CHAR_LAST      = 3'h7;

  // Reset values: 25.175 MHz and 28.322 MHz from a 14.31818 MHz reference
  localparam logic [7:0] RST_MULT_25 = 8'h4e;
  localparam logic [7:0] RST_MULT_28 = 8'h58;
  localparam logic [7:0] RST_DIV     = 8'h59;
  localparam logic [7:0] RST_HIGH    = 8'h00;
  localparam logic [7:0] RST_POST    = 8'h11;
  localparam logic [7:0] RST_MEM_CTL = 8'h11;
  localparam logic [7:0] RST_MISC    = 8'h00;

  typedef enum logic [1:0] {SET_ZERO, SET_ONE, SET_TWO} dps_set_type;

  typedef struct packed {
    logic [9:0] mult_count;
    logic [9:0] div_count;
    logic [5:0] post_ratio;
    logic       loop_div16;
    logic       ref_div4;
    logic       ntsc_div;
  } dps_cfg_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } dps_bus_type;

endpackage

// File: tb/dps_synth_ctrl_tb.sv
// Self-checking bench for the synthesizer control block
`timescale 1ns/1ps
module dps_synth_ctrl_tb;
  import dps_pkg::*;
  logic                CLK_I;
  logic                RST_N_I;
  dps_bus_type         bus;
  logic [7:0]          rdata;
  logic                pix_clk;
  dps_cfg_type         pcfg;
  dps_cfg_type         mcfg;
  logic                msel;
  logic [1:0]          pset;
  logic                pret, mret, pstep, mstep, tick;
  int                  errors, checks_done, n_pret, n_pstep, n_mret, n_tick, k0;
  int                  n_mstep, k1;
  // Reset values of indices 0x00..0x0f
  logic [7:0]          rst_rows [16] = '{8'h4e, 8'h59, 8'h00, 8'h11, 8'h58, 8'h59, 8'h00, 8'h11,
                                        8'h4e, 8'h59, 8'h00, 8'h11, 8'h4e, 8'h59, 8'h11, 8'h00};

  dps_synth_ctrl DUT (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .BUS_I(bus), .RDATA_O(rdata),
    .PIXEL_CLOCK_I(pix_clk), .PIXEL_CFG_O(pcfg), .MEM_CFG_O(mcfg), .MEM_CLK_SEL_O(msel),
    .PIXEL_SET_O(pset), .PIXEL_RETUNE_O(pret), .MEM_RETUNE_O(mret), .PIXEL_POST_STEP_O(pstep),
    .MEM_POST_STEP_O(mstep), .CHAR_TICK_O(tick));

  initial begin
    CLK_I = 1'b0;
    forever #50 CLK_I = ~CLK_I;
  end

  // Event pulses are one cycle wide, so counting at each edge catches them all
  always @(posedge CLK_I) begin
    n_pret  <= n_pret + int'(pret === 1'b1);
    n_mret  <= n_mret + int'(mret === 1'b1);
    n_pstep <= n_pstep + int'(pstep === 1'b1);
    n_tick  <= n_tick + int'(tick === 1'b1);
    n_mstep <= n_mstep + int'(mstep === 1'b1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_I);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge CLK_I);
    bus.wr <= 1'b0;
  endtask

  // Write, then let derived outputs land one edge later
  task automatic wrs(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    @(posedge CLK_I);
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK_I);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge CLK_I);
    bus.rd <= 1'b0;
    #1 chk(rdata, exp, "read data");
    @(posedge CLK_I);
    #1 chk(rdata, 8'h00, "read data after its cycle");
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge CLK_I);
    errors++;
    final_report;
  end

  initial begin
    RST_N_I = 1'b0;
    bus = '0;
    pix_clk = 1'b0;
    {errors, checks_done, n_pret, n_pstep, n_mret, n_tick, n_mstep} = '0;
    repeat (10) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    #1 chk({pcfg.mult_count, pcfg.div_count, pcfg.post_ratio}, {10'd80, 10'd91, 6'd2}, "reset cfg");
    chk({msel, pset, mcfg.mult_count}, {1'b0, 2'd0, 10'd80}, "reset mem");
    for (int i = 0; i < 16; i++) rd_chk(8'(i), rst_rows[i]);
    $display("test reset values done");
    // Pixel set zero dividers with high bits above the low byte
    k0 = n_pret;
    wrs(OFS_SET0_MULT_LOW, 8'h34);
    wrs(OFS_SET0_HIGH_BITS, 8'h21);
    chk({pcfg.mult_count, pcfg.div_count}, {10'h136, 10'h25b}, "pixel M N");
    // Last pulse is counted one edge after it shows
    @(posedge CLK_I);
    #1;
    chk(n_pret - k0, 2, "pixel retune pulses");
    $display("test pixel dividers done");
    // Every post code; codes past 5 saturate and so give no step
    k0 = n_pstep;
    for (int c = 0; c < 8; c++) begin
      wrs(OFS_SET0_POST_DIV, {1'b0, 3'(c), 4'h1});
      chk(pcfg.post_ratio, (c > 5) ? 32 : (1 << c), "post ratio");
    end
    chk(n_pstep - k0, 6, "post step pulses");
    wrs(OFS_SET0_POST_DIV, 8'h16);
    chk({pcfg.loop_div16, pcfg.ref_div4, pcfg.ntsc_div}, 3'b111, "loop bits");
    $display("test post divider done");
    // Set select through the misc output register
    wrs(OFS_MISC_OUTPUT, 8'h04);
    chk({pset, pcfg.mult_count, pcfg.div_count}, {2'd1, 10'd90, 10'd91}, "set one");
    wrs(OFS_MISC_OUTPUT, 8'h08);
    chk({pset, pcfg.mult_count, pcfg.div_count}, {2'd2, 10'd80, 10'd91}, "set two direct");
    wrs(OFS_MISC_OUTPUT, 8'h0c);
    chk({pset, pcfg.mult_count, pcfg.div_count}, {2'd2, 10'd80, 10'd91}, "set two");
    $display("test set select done");
    // Memory loop in the documented order, bit 7 of M ignored
    k0 = n_mret;
    k1 = n_mstep;
    wrs(OFS_MEM_CONTROL, 8'h11);
    wrs(OFS_MEM_MULT, 8'hfd);
    wrs(OFS_MEM_DIV, 8'h05);
    chk({msel, mcfg.mult_count, mcfg.div_count}, {1'b0, 10'h07f, 10'h007}, "mem M N");
    wrs(OFS_MEM_CONTROL, 8'hb1);
    chk({msel, mcfg.post_ratio}, {1'b1, 6'd8}, "mem select post");
    @(posedge CLK_I);
    #1;
    chk(n_mret - k0 > 0, 1, "mem retune");
    chk(n_mstep - k1, 1, "mem post step pulses");
    $display("test memory clock done");
    // Unmapped index: write ignored, read gives zero
    wrs(8'h20, 8'h5a);
    rd_chk(8'h20, 8'h00);
    rd_chk(OFS_SET0_MULT_LOW, 8'h34);
    $display("test unmapped done");
    // Character tick after eight filtered pixel clock rises
    k0 = n_tick;
    for (int e = 0; e < 8; e++) begin
      if (e == 7) chk(n_tick - k0, 0, "early tick");
      @(posedge CLK_I) pix_clk <= 1'b1;
      repeat (4) @(posedge CLK_I);
      pix_clk <= 1'b0;
      repeat (4) @(posedge CLK_I);
    end
    #1 chk(n_tick - k0, 1, "tick count");
    $display("test character tick done");
    // Reset in mid-run restores the fixed memory clock and set zero
    @(posedge CLK_I) RST_N_I <= 1'b0;
    #1 chk({msel, pset, mcfg.mult_count}, {1'b0, 2'd0, 10'd80}, "mid reset");
    @(posedge CLK_I) RST_N_I <= 1'b1;
    rd_chk(OFS_SET0_MULT_LOW, 8'h4e);
    $display("test second reset done");
    final_report;
  end
endmodule
